// [comport_pkg.sv]
// Register map, field layout and bus carrier types for the port register bank
// Summary of operation
// R1: Threshold zero never raises transmit FIFO interrupt; N raises it below N bytes.
// R2: Transmit threshold field resets to zero, interrupts off until programmed.
// R3: Interrupt control and status register decodes at byte offset 0x10.
// R4: Status register always present, 32-bit, answering at 0x2c and 0x3c.
// R5: Both status offsets reach one physical register; writes visible through both.
// R6: Transmit FIFO interrupt flag clears on writing one; zero leaves it.
// R7: Threshold reads zero, ignores writes when no transmit interrupt support.
package comport_pkg;
  localparam logic [7:0] IRQ_CONTROL_STATUS_OFS = 8'h10;
  localparam logic [7:0] PORT_STATUS_OFS        = 8'h2c;
  localparam logic [7:0] PORT_STATUS_ALIAS_OFS  = 8'h3c;
  localparam logic [7:0] TX_FEATURE_ID_OFS      = 8'h48;
  localparam logic [7:0] IRQ_MASK_OFS           = 8'h50;
  localparam int TX_FIFO_IRQ_THRESHOLD_LSB      = 0;
  localparam int TX_FIFO_IRQ_THRESHOLD_W        = 4;
  localparam int TX_FIFO_IRQ_FLAG_BIT      = 15;
  localparam int LINKERR_BIT    = 30;
  localparam int TXLEVEL_LSB    = 0;
  localparam int TXLEVEL_W      = 8;
  localparam int TX_IRQ_SUPPORTED_BIT      = 0;
  localparam logic [3:0]  TX_FIFO_IRQ_THRESHOLD_RESET = 4'h0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_t;
endpackage

// [comport_regs.sv]
// Port register bank: irq control/status, aliased port status, irq mask
`timescale 1ns/1ns
`default_nettype none
module comport_regs (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  // Wishbone slave
  input  wire comport_pkg::wb_req_t   wb_req,
  output var  logic [31:0]            wb_dat_o,
  output var  logic                   wb_ack_o,
  // Transmit engine status
  input  wire logic [7:0]             tx_fifo_level,
  input  wire logic                   link_error,
  input  wire logic                   tx_irq_supported,
  // Interrupt
  output var  logic                   irq
);
  logic [3:0]  tx_fifo_irq_threshold;
  logic        tx_fifo_irq_flag;
  logic        link_err_flag;
  logic [1:0]  irq_mask;
  logic        tx_cond;
  logic        access;
  logic        wr;
  logic        hit_irq_control_status;
  logic        hit_sr;
  logic [31:0] next_rdata;

  assign access = wb_req.cyc && wb_req.stb && !wb_ack_o;
  // Writes land on the edge where the master sees ack
  assign wr     = wb_req.cyc && wb_req.stb && wb_req.we && wb_ack_o;
  assign hit_irq_control_status = wb_req.adr == comport_pkg::IRQ_CONTROL_STATUS_OFS; // R3
  assign hit_sr = (wb_req.adr == comport_pkg::PORT_STATUS_OFS) ||
                  (wb_req.adr == comport_pkg::PORT_STATUS_ALIAS_OFS); // R4 R5

  // Level below threshold; zero threshold never fires
  assign tx_cond = tx_irq_supported && (tx_fifo_irq_threshold != 4'h0) &&
                   ({4'h0, tx_fifo_irq_threshold} > tx_fifo_level); // R1

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_fifo_irq_threshold <= comport_pkg::TX_FIFO_IRQ_THRESHOLD_RESET; // R2
    end else if (!tx_irq_supported) begin
      tx_fifo_irq_threshold <= 4'h0; // R7
    end else if (wr && hit_irq_control_status && wb_req.sel[0]) begin
      tx_fifo_irq_threshold <= wb_req.dat[3:0];
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_fifo_irq_flag <= 1'b0;
    end else if (tx_cond) begin
      tx_fifo_irq_flag <= 1'b1; // R1
    end else if (!tx_irq_supported) begin
      tx_fifo_irq_flag <= 1'b0;
    end else if (wr && hit_irq_control_status && wb_req.sel[1] && wb_req.dat[15]) begin
      tx_fifo_irq_flag <= 1'b0; // R6
    end
  end

  // Single physical status register behind both offsets
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link_err_flag <= 1'b0;
    end else if (link_error) begin
      link_err_flag <= 1'b1;
    end else if (wr && hit_sr && wb_req.sel[3] && wb_req.dat[30]) begin
      link_err_flag <= 1'b0; // R5
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_mask <= 2'h0;
    end else if (wr && wb_req.sel[0] &&
                 wb_req.adr == comport_pkg::IRQ_MASK_OFS) begin
      irq_mask <= wb_req.dat[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (tx_fifo_irq_flag && irq_mask[0]) ||
             (link_err_flag && irq_mask[1]);
    end
  end

  always_comb begin
    next_rdata = comport_pkg::UNMAPPED_DATA;
    if (hit_irq_control_status) begin
      next_rdata[15] = tx_fifo_irq_flag;
      next_rdata[3:0] = tx_fifo_irq_threshold; // R7
    end else if (hit_sr) begin
      next_rdata[30] = link_err_flag;
      next_rdata[7:0] = tx_fifo_level;
    end else if (wb_req.adr == comport_pkg::TX_FEATURE_ID_OFS) begin
      next_rdata[0] = tx_irq_supported;
    end else if (wb_req.adr == comport_pkg::IRQ_MASK_OFS) begin
      next_rdata[1:0] = irq_mask;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access) begin
      wb_dat_o <= next_rdata;
    end
  end

  a_zero_thresh_quiet: assert property ( // R1
    @(posedge core_clk) disable iff (sys_rst)
    (tx_fifo_irq_threshold == 4'h0 && !tx_fifo_irq_flag) |=> !tx_fifo_irq_flag)
    else $error("flag set with zero threshold");

  a_below_sets_flag: assert property ( // R1
    @(posedge core_clk) disable iff (sys_rst)
    tx_cond |=> tx_fifo_irq_flag)
    else $error("level below threshold did not set flag");

  a_thresh_reset_zero: assert property ( // R2
    @(posedge core_clk)
    $fell(sys_rst) |-> tx_fifo_irq_threshold == 4'h0)
    else $error("threshold not zero after reset");

  a_irq_control_status_read_value: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    (access && !wb_req.we && hit_irq_control_status) |=>
      wb_ack_o && wb_dat_o[3:0] == tx_fifo_irq_threshold)
    else $error("irq_control_status read wrong");

  a_sr_alias_read: assert property ( // R4
    @(posedge core_clk) disable iff (sys_rst)
    (access && hit_sr) |=> wb_ack_o && wb_dat_o[30] == $past(link_err_flag))
    else $error("status alias read wrong");

  a_sr_alias_clear: assert property ( // R5
    @(posedge core_clk) disable iff (sys_rst)
    (wr && wb_req.adr == comport_pkg::PORT_STATUS_ALIAS_OFS && wb_req.sel[3]
     && wb_req.dat[30] && !link_error) |=> !link_err_flag)
    else $error("alias write did not clear");

  a_w1c_flag: assert property ( // R6
    @(posedge core_clk) disable iff (sys_rst)
    (wr && hit_irq_control_status && wb_req.sel[1] && !tx_cond && tx_irq_supported) |=>
      tx_fifo_irq_flag == ($past(tx_fifo_irq_flag) && !$past(wb_req.dat[15])))
    else $error("flag write-one-to-clear wrong");

  a_nosupport_zero: assert property ( // R7
    @(posedge core_clk) disable iff (sys_rst)
    !tx_irq_supported |=> tx_fifo_irq_threshold == 4'h0)
    else $error("threshold live without support");

  a_ack_one_pulse: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_follows_req: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    (wb_req.cyc && wb_req.stb && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged");

  a_ack_needs_req: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    !(wb_req.cyc && wb_req.stb) |=> !wb_ack_o)
    else $error("ack without request");

  a_irq_off_masked: assert property ( // R1
    @(posedge core_clk) disable iff (sys_rst)
    (irq_mask == 2'h0) |=> !irq)
    else $error("irq raised while fully masked");

  a_irq_tx_source: assert property ( // R1
    @(posedge core_clk) disable iff (sys_rst)
    (tx_fifo_irq_flag && irq_mask[0]) |=> irq)
    else $error("unmasked tx flag gave no irq");

  a_irq_link_source: assert property ( // R5
    @(posedge core_clk) disable iff (sys_rst)
    (link_err_flag && irq_mask[1]) |=> irq)
    else $error("unmasked link error gave no irq");

  a_irq_no_source: assert property ( // R1
    @(posedge core_clk) disable iff (sys_rst)
    (!tx_fifo_irq_flag && !link_err_flag) |=> !irq)
    else $error("irq without a pending flag");

  a_flag_sticky: assert property ( // R6
    @(posedge core_clk) disable iff (sys_rst)
    (tx_fifo_irq_flag && tx_irq_supported && !wr) |=> tx_fifo_irq_flag)
    else $error("tx flag dropped without a clear");

  a_link_sticky: assert property ( // R5
    @(posedge core_clk) disable iff (sys_rst)
    (link_err_flag && !wr) |=> link_err_flag)
    else $error("link flag dropped without a clear");

  a_link_sets: assert property ( // R4
    @(posedge core_clk) disable iff (sys_rst)
    link_error |=> link_err_flag)
    else $error("link error did not set flag");

  a_set_beats_clear: assert property ( // R6
    @(posedge core_clk) disable iff (sys_rst)
    (tx_cond && wr && hit_irq_control_status && wb_req.dat[15]) |=> tx_fifo_irq_flag)
    else $error("clear won over set");

  a_nosupport_flag: assert property ( // R7
    @(posedge core_clk) disable iff (sys_rst)
    !tx_irq_supported |=> !tx_fifo_irq_flag)
    else $error("tx flag live without support");

  a_thresh_write: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    (wr && hit_irq_control_status && wb_req.sel[0] && tx_irq_supported) |=>
      tx_fifo_irq_threshold == $past(wb_req.dat[3:0]))
    else $error("threshold write lost");

  a_thresh_hold: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    (!wr && tx_irq_supported) |=> $stable(tx_fifo_irq_threshold))
    else $error("threshold changed without a write");

  a_mask_write: assert property ( // R1
    @(posedge core_clk) disable iff (sys_rst)
    (wr && wb_req.sel[0] && wb_req.adr == comport_pkg::IRQ_MASK_OFS) |=>
      irq_mask == $past(wb_req.dat[1:0]))
    else $error("mask write lost");

  a_sr_read_level: assert property ( // R4
    @(posedge core_clk) disable iff (sys_rst)
    (access && !wb_req.we && hit_sr) |=>
      wb_dat_o[7:0] == $past(tx_fifo_level))
    else $error("status level read wrong");

  a_fid_read: assert property ( // R7
    @(posedge core_clk) disable iff (sys_rst)
    (access && !wb_req.we &&
     wb_req.adr == comport_pkg::TX_FEATURE_ID_OFS) |=>
      wb_dat_o[0] == $past(tx_irq_supported))
    else $error("feature bit read wrong");

  a_irq_control_status_flag_read: assert property ( // R6
    @(posedge core_clk) disable iff (sys_rst)
    (access && !wb_req.we && hit_irq_control_status) |=>
      wb_dat_o[15] == $past(tx_fifo_irq_flag))
    else $error("tx flag read wrong");

  a_irq_control_status_reserved: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    (access && !wb_req.we && hit_irq_control_status) |=>
      wb_dat_o[14:4] == 11'h000 && wb_dat_o[31:16] == 16'h0000)
    else $error("irq_control_status reserved bits not zero");

  a_unmapped_read: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    (access && !wb_req.we && !hit_irq_control_status && !hit_sr &&
     wb_req.adr != comport_pkg::TX_FEATURE_ID_OFS &&
     wb_req.adr != comport_pkg::IRQ_MASK_OFS) |=>
      wb_dat_o == comport_pkg::UNMAPPED_DATA)
    else $error("unmapped read not zero");

  a_dat_hold: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    !access |=> $stable(wb_dat_o))
    else $error("read data moved while idle");

  a_sr_base_clear: assert property ( // R5
    @(posedge core_clk) disable iff (sys_rst)
    (wr && wb_req.adr == comport_pkg::PORT_STATUS_OFS && wb_req.sel[3]
     && wb_req.dat[30] && !link_error) |=> !link_err_flag)
    else $error("base write did not clear");

  a_quiet_after_reset: assert property ( // R2
    @(posedge core_clk)
    $fell(sys_rst) |-> !irq && !wb_ack_o && !tx_fifo_irq_flag)
    else $error("outputs not quiet after reset");
endmodule // comport_regs
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the port register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic                 core_clk         = 1'b0;
  logic                 sys_rst          = 1'b1;
  comport_pkg::wb_req_t wb_req           = '0;
  logic [7:0]           tx_fifo_level    = 8'hff;
  logic                 link_error       = 1'b0;
  logic                 tx_irq_supported = 1'b1;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic                 irq;
  logic [31:0]          q;
  logic [3:0]           thr;
  int                   num_errors, samples_checked, cyc_cnt;

  comport_regs DUT (.core_clk(core_clk), .sys_rst(sys_rst), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_fifo_level(tx_fifo_level),
    .link_error(link_error), .tx_irq_supported(tx_irq_supported), .irq(irq));

  always #25 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt > 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One classic cycle; ack sampled at the edge itself
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_req <= '{1'b1, 1'b1, w, 4'hf, a, d};
    @(posedge core_clk iff wb_ack_o === 1'b1);
    q = wb_dat_o;
    wb_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  function automatic logic [31:0] irq_control_status(input logic [3:0] t, input logic [7:0] l);
    return {16'h0, (t != 4'h0) && (l < {4'h0, t}), 11'h0, t};
  endfunction

  initial begin
    void'($urandom(83));
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h10, 32'h0);
    rd(8'h48, 32'h1);
    rd(8'h20, comport_pkg::UNMAPPED_DATA);
    for (int i = 0; i < 40; i++) begin
      thr = (i < 16) ? i[3:0] : 4'($urandom_range(15, 1));
      tx_fifo_level <= 8'hff;
      wb(1'b1, 8'h10, 32'h8000);
      tx_fifo_level <= (i < 16) ? 8'h00 : 8'($urandom_range(20, 0));
      wb(1'b1, 8'h10, {28'h0, thr});
      repeat (3) @(posedge core_clk);
      rd(8'h10, irq_control_status(thr, tx_fifo_level));
    end
    tx_fifo_level <= 8'h00;
    wb(1'b1, 8'h10, 32'hf);
    wb(1'b1, 8'h50, 32'h1);
    tx_fifo_level <= 8'hff;
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h10, 32'hf);
    rd(8'h10, 32'h800f);
    wb(1'b1, 8'h10, 32'h800f);
    rd(8'h10, 32'hf);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    for (int k = 0; k < 2; k++) begin
      link_error <= 1'b1;
      @(posedge core_clk);
      link_error <= 1'b0;
      rd(k ? 8'h3c : 8'h2c, 32'h4000_00ff);
      wb(1'b1, k ? 8'h2c : 8'h3c, 32'h4000_0000);
      rd(k ? 8'h3c : 8'h2c, 32'hff);
    end
    tx_irq_supported <= 1'b0;
    tx_fifo_level <= 8'h00;
    wb(1'b1, 8'h10, 32'h5);
    rd(8'h10, 32'h0);
    rd(8'h48, 32'h0);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
